// ==== verilog/cpu_exec_pkg.sv ====
// Package: opcodes, flag positions, cycle figures and register map for the execution unit
package cpu_exec_pkg;
    // Operation codes presented on the operation register
    localparam logic [4:0] OP_NOP = 5'h00;
    localparam logic [4:0] OP_ROT_R_ACC = 5'h01;
    localparam logic [4:0] OP_ROT_R_MEM = 5'h02;
    localparam logic [4:0] OP_ROT_L_ACC = 5'h03;
    localparam logic [4:0] OP_ROT_L_MEM = 5'h04;
    localparam logic [4:0] OP_CLR = 5'h05;
    localparam logic [4:0] OP_BIT_CLR = 5'h06;
    localparam logic [4:0] OP_BIT_SET = 5'h07;
    localparam logic [4:0] OP_B0_BIT_CLR = 5'h08;
    localparam logic [4:0] OP_B0_BIT_SET = 5'h09;
    localparam logic [4:0] OP_CMP_IMM = 5'h0a;
    localparam logic [4:0] OP_CMP_MEM = 5'h0b;
    localparam logic [4:0] OP_INC_ACC = 5'h0c;
    localparam logic [4:0] OP_INC_MEM = 5'h0d;
    localparam logic [4:0] OP_DEC_ACC = 5'h0e;
    localparam logic [4:0] OP_DEC_MEM = 5'h0f;
    localparam logic [4:0] OP_SKIP_CLR = 5'h10;
    localparam logic [4:0] OP_SKIP_SET = 5'h11;
    localparam logic [4:0] OP_B0_SKIP_CLR = 5'h12;
    localparam logic [4:0] OP_B0_SKIP_SET = 5'h13;
    localparam logic [4:0] OP_JMP = 5'h14;
    localparam logic [4:0] OP_CALL = 5'h15;
    localparam logic [4:0] OP_RET = 5'h16;
    localparam logic [4:0] OP_RETURN_FROM_INTERRUPT = 5'h17;
    localparam logic [4:0] OP_PUSH = 5'h18;
    localparam logic [4:0] OP_POP = 5'h19;

    // Flag bit positions in the program flag register
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_NPD = 6;
    localparam int FLAG_NT0 = 7;
    localparam logic [7:0] FLAG_SAVE_MASK = 8'h3f;

    // Cycle figures, system register limit and stack depth
    localparam logic [2:0] CYC_BASE = 3'h1;
    localparam logic [2:0] CYC_BRANCH = 3'h2;
    localparam logic [7:0] SYS_REG_LIMIT = 8'h80;
    localparam int STACK_DEPTH = 8;

    // Register word byte addresses
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_ACC = 8'h04;
    localparam logic [7:0] ADDR_FLAG = 8'h08;
    localparam logic [7:0] ADDR_PC = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_MEM = 8'h14;
    localparam logic [7:0] ADDR_CFG = 8'h18;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
endpackage

// ==== verilog/cpu_exec.sv ====
// Execution unit for rotate, bit, skip, branch, stack and save/restore operations
`timescale 1ns/100ps
module cpu_exec (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic global_int_enable,
    output logic busy
);
    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic ack_q;
    logic req;
    logic wr;
    logic hit;
    logic [7:0] adr;

    assign adr = wb_adr_i[7:0];
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign hit = (wb_adr_i[31:8] == 24'h000000) && (adr <= cpu_exec_pkg::ADDR_CFG)
        && (adr[1:0] == 2'h0);
    assign wr = req & wb_we_i & hit & wb_sel_i[0];

    // One-cycle answer, dropped the cycle after
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end
    assign wb_ack_o = ack_q & hit;
    assign wb_err_o = ack_q & ~hit;

    // ----------------------------------------------------------------
    // Architectural state
    // ----------------------------------------------------------------
    logic [7:0] acc_q;
    logic [7:0] flag_q;
    logic [15:0] pc_q;
    logic [7:0] acc_save_q;
    logic [7:0] flag_save_q;
    logic [15:0] stack_q [cpu_exec_pkg::STACK_DEPTH];
    logic [2:0] sp_q;
    logic gie_q;
    logic [7:0] mem_q;
    logic [1:0] page_q;
    logic [7:0] oper_q;
    logic [2:0] bit_q;
    logic [7:0] addr_q;
    logic bank_q;
    logic [13:0] target_q;
    logic [4:0] op_q;
    logic [2:0] cnt_q;
    logic skip_q;
    logic mem_wr_q;
    logic [7:0] wr_addr_q;
    logic wr_bank_q;

    // Start of an operation from a command write
    logic start;
    assign start = wr && adr == cpu_exec_pkg::ADDR_CMD && cnt_q == 3'h0;
    assign busy = cnt_q != 3'h0;
    assign global_int_enable = gie_q;

    // Cycle count of the memory-write term
    function automatic logic [2:0] mem_term(input logic [7:0] a);
        mem_term = (a < cpu_exec_pkg::SYS_REG_LIMIT) ? 3'h0 : 3'h1;
    endfunction

    // Rotate through carry
    function automatic logic [8:0] rot(input logic [7:0] v, input logic c, input logic left);
        rot = left ? {v[7], v[6:0], c} : {v[0], c, v[7:1]};
    endfunction

    // ----------------------------------------------------------------
    // Decode and execute
    // ----------------------------------------------------------------
    logic [7:0] res;
    logic [7:0] acc_d;
    logic [7:0] flag_d;
    logic [15:0] pc_d;
    logic to_mem;
    logic skip;
    logic [2:0] cyc;
    logic [8:0] diff;
    logic [8:0] r9;
    logic [4:0] op;
    logic [7:0] opnd;
    logic [7:0] bmask;

    assign op = wb_dat_i[4:0];
    assign opnd = (op == cpu_exec_pkg::OP_CMP_IMM) ? oper_q : mem_q;
    assign bmask = 8'h01 << bit_q;

    always_comb begin
        res = mem_q;
        acc_d = acc_q;
        flag_d = flag_q;
        pc_d = pc_q + 16'h0001;
        to_mem = 1'b0;
        skip = 1'b0;
        cyc = cpu_exec_pkg::CYC_BASE;
        diff = {1'b0, acc_q} - {1'b0, opnd};
        r9 = rot(mem_q, flag_q[cpu_exec_pkg::FLAG_C],
            op == cpu_exec_pkg::OP_ROT_L_ACC || op == cpu_exec_pkg::OP_ROT_L_MEM);
        case (op)
            cpu_exec_pkg::OP_ROT_R_ACC, cpu_exec_pkg::OP_ROT_L_ACC: begin
                acc_d = r9[7:0];
                flag_d[cpu_exec_pkg::FLAG_C] = r9[8];
            end
            cpu_exec_pkg::OP_ROT_R_MEM, cpu_exec_pkg::OP_ROT_L_MEM: begin
                res = r9[7:0];
                acc_d = r9[7:0];
                flag_d[cpu_exec_pkg::FLAG_C] = r9[8];
                to_mem = 1'b1;
            end
            cpu_exec_pkg::OP_CLR: begin
                res = 8'h00;
                to_mem = 1'b1;
            end
            cpu_exec_pkg::OP_BIT_CLR, cpu_exec_pkg::OP_B0_BIT_CLR: begin
                res = mem_q & ~bmask;
                to_mem = 1'b1;
            end
            cpu_exec_pkg::OP_BIT_SET, cpu_exec_pkg::OP_B0_BIT_SET: begin
                res = mem_q | bmask;
                to_mem = 1'b1;
            end
            cpu_exec_pkg::OP_CMP_IMM, cpu_exec_pkg::OP_CMP_MEM: begin
                flag_d[cpu_exec_pkg::FLAG_Z] = diff[7:0] == 8'h00;
                flag_d[cpu_exec_pkg::FLAG_C] = ~diff[8];
                skip = diff[7:0] == 8'h00;
            end
            cpu_exec_pkg::OP_INC_ACC: begin
                acc_d = mem_q + 8'h01;
                skip = acc_d == 8'h00;
            end
            cpu_exec_pkg::OP_INC_MEM: begin
                res = mem_q + 8'h01;
                to_mem = 1'b1;
                skip = res == 8'h00;
            end
            cpu_exec_pkg::OP_DEC_ACC: begin
                acc_d = mem_q - 8'h01;
                skip = acc_d == 8'h00;
            end
            cpu_exec_pkg::OP_DEC_MEM: begin
                res = mem_q - 8'h01;
                to_mem = 1'b1;
                skip = res == 8'h00;
            end
            cpu_exec_pkg::OP_SKIP_CLR, cpu_exec_pkg::OP_B0_SKIP_CLR: begin
                skip = ~mem_q[bit_q];
            end
            cpu_exec_pkg::OP_SKIP_SET, cpu_exec_pkg::OP_B0_SKIP_SET: begin
                skip = mem_q[bit_q];
            end
            cpu_exec_pkg::OP_JMP, cpu_exec_pkg::OP_CALL: begin
                pc_d = {page_q, target_q};
                cyc = cpu_exec_pkg::CYC_BRANCH;
            end
            cpu_exec_pkg::OP_RET, cpu_exec_pkg::OP_RETURN_FROM_INTERRUPT: begin
                pc_d = stack_q[sp_q - 3'h1];
                cyc = cpu_exec_pkg::CYC_BRANCH;
            end
            cpu_exec_pkg::OP_POP: begin
                acc_d = acc_save_q;
                flag_d = (flag_save_q & cpu_exec_pkg::FLAG_SAVE_MASK)
                    | (flag_q & ~cpu_exec_pkg::FLAG_SAVE_MASK);
            end
            default: begin
                acc_d = acc_q;
            end
        endcase
        if (to_mem) begin
            cyc = cyc + mem_term(addr_q);
        end
        if (skip) begin
            pc_d = pc_q + 16'h0002;
            cyc = cyc + 3'h1;
        end
    end

    // Operation register, cycle counter and latched skip
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            op_q <= cpu_exec_pkg::OP_NOP;
            cnt_q <= 3'h0;
            skip_q <= 1'b0;
        end else if (start) begin
            op_q <= op;
            cnt_q <= cyc;
            skip_q <= skip;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end

    // Accumulator, flags and program counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_q <= cpu_exec_pkg::ACC_RST;
            flag_q <= cpu_exec_pkg::FLAG_RST;
            pc_q <= cpu_exec_pkg::PC_RST;
        end else if (start) begin
            acc_q <= acc_d;
            flag_q <= flag_d;
            pc_q <= pc_d;
        end else if (wr) begin
            if (adr == cpu_exec_pkg::ADDR_ACC) begin
                acc_q <= wb_dat_i[7:0];
            end
            if (adr == cpu_exec_pkg::ADDR_FLAG) begin
                flag_q <= wb_dat_i[7:0];
            end
            if (adr == cpu_exec_pkg::ADDR_PC) begin
                pc_q <= wb_dat_i[15:0];
            end
        end
    end

    // Save buffers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_save_q <= cpu_exec_pkg::ACC_RST;
            flag_save_q <= cpu_exec_pkg::FLAG_RST;
        end else if (start && op == cpu_exec_pkg::OP_PUSH) begin
            acc_save_q <= acc_q;
            flag_save_q <= flag_q & cpu_exec_pkg::FLAG_SAVE_MASK;
        end
    end

    // Return stack and interrupt enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sp_q <= 3'h0;
            gie_q <= 1'b0;
            for (int i = 0; i < cpu_exec_pkg::STACK_DEPTH; i++) begin
                stack_q[i] <= 16'h0000;
            end
        end else if (start) begin
            if (op == cpu_exec_pkg::OP_CALL) begin
                stack_q[sp_q] <= pc_q + 16'h0001;
                sp_q <= sp_q + 3'h1;
            end else if (op == cpu_exec_pkg::OP_RET || op == cpu_exec_pkg::OP_RETURN_FROM_INTERRUPT) begin
                sp_q <= sp_q - 3'h1;
                if (op == cpu_exec_pkg::OP_RETURN_FROM_INTERRUPT) begin
                    gie_q <= 1'b1;
                end
            end
        end else if (wr && adr == cpu_exec_pkg::ADDR_CFG) begin
            gie_q <= wb_dat_i[31];
        end
    end

    // Operand memory image and its write back
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_q <= 8'h00;
            mem_wr_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_bank_q <= 1'b0;
        end else if (start) begin
            mem_wr_q <= to_mem;
            wr_addr_q <= addr_q;
            wr_bank_q <= bank_q & ~(op == cpu_exec_pkg::OP_B0_BIT_CLR
                || op == cpu_exec_pkg::OP_B0_BIT_SET || op == cpu_exec_pkg::OP_B0_SKIP_CLR
                || op == cpu_exec_pkg::OP_B0_SKIP_SET);
            if (to_mem) begin
                mem_q <= res;
            end
        end else if (wr && adr == cpu_exec_pkg::ADDR_MEM) begin
            mem_q <= wb_dat_i[7:0];
        end
    end

    // Operand configuration
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oper_q <= 8'h00;
            bit_q <= 3'h0;
            addr_q <= 8'h00;
            bank_q <= 1'b0;
            target_q <= 14'h0000;
            page_q <= 2'h0;
        end else if (wr && adr == cpu_exec_pkg::ADDR_CFG) begin
            oper_q <= wb_dat_i[7:0];
            bit_q <= wb_dat_i[10:8];
            bank_q <= wb_dat_i[11];
            page_q <= wb_dat_i[13:12];
            addr_q <= wb_dat_i[23:16];
        end else if (wr && adr == cpu_exec_pkg::ADDR_STAT) begin
            target_q <= wb_dat_i[13:0];
        end
    end

    // Read data, held until the next read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_dat_o <= 32'h00000000;
        end else if (req && !wb_we_i) begin
            case (adr)
                cpu_exec_pkg::ADDR_ACC: wb_dat_o <= {24'h000000, acc_q};
                cpu_exec_pkg::ADDR_FLAG: wb_dat_o <= {24'h000000, flag_q};
                cpu_exec_pkg::ADDR_PC: wb_dat_o <= {16'h0000, pc_q};
                cpu_exec_pkg::ADDR_STAT: wb_dat_o <= {8'h00, wr_addr_q, 3'h0, cnt_q,
                    skip_q, mem_wr_q, wr_bank_q, gie_q, busy, sp_q, 2'h0};
                cpu_exec_pkg::ADDR_MEM: wb_dat_o <= {24'h000000, mem_q};
                cpu_exec_pkg::ADDR_CMD: wb_dat_o <= {27'h0000000, op_q};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end
endmodule

// ==== dv/cpu_exec_chk.sv ====
// Checker: bus handshake, busy length and status output relations
`timescale 1ns/100ps
module cpu_exec_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic global_int_enable,
    input wire logic busy
);
    logic [3:0] busy_run_q;
    logic hit;
    logic wr;

    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    // Mapped, aligned address and a write on the bus
    assign hit = wb_adr_i[31:8] == 24'h0 && wb_adr_i[1:0] == 2'h0 && wb_adr_i[7:0] <= 8'h18;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i;

    // Consecutive busy cycles seen so far
    always_ff @(posedge sys_clk) begin
        if (rst || !busy) begin
            busy_run_q <= 4'h0;
        end else begin
            busy_run_q <= busy_run_q + 4'h1;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence req_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_mapped_ack: assert property (req_taken ##0 hit |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not acknowledged");
    a_unmapped_err: assert property (req_taken ##0 !hit |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request without error");
    a_answer_has_req: assert property ((wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("answer without request");
    a_busy_bound: assert property (busy |-> busy_run_q <= 4'h2)
        else $error("busy longer than three cycles");
    a_busy_from_cmd: assert property ($rose(busy) |-> $past(wr, 1) || $past(wr, 2))
        else $error("busy without command write");
    a_gie_cause: assert property ($changed(global_int_enable) |-> $past(wr, 1) || $past(wr, 2))
        else $error("interrupt enable changed on its own");
    a_rdata_hold: assert property ($changed(wb_dat_o) |-> $past(wb_cyc_i && !wb_we_i))
        else $error("read data changed without read");
    a_reset_clear: assert property ($fell(rst) |-> !busy && !wb_ack_o && !global_int_enable)
        else $error("outputs not cleared by reset");
endmodule

bind cpu_exec cpu_exec_chk u_cpu_exec_chk (.sys_clk(sys_clk), .rst(rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .global_int_enable(global_int_enable), .busy(busy));

// ==== dv/cpu_exec_tb.sv ====
// Testbench: register-level operation scenarios for the execution unit
`timescale 1ns/100ps
module cpu_exec_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [3:0] lanes = 4'hf;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [31:0] rdat;
    logic ack;
    logic err;
    logic gie;
    logic busy;
    logic [31:0] q;
    logic e;
    int error_cnt = 0;
    int checks = 0;
    int busy_cnt = 0;

    cpu_exec u_cpu_exec (.sys_clk(sys_clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .wb_err_o(err), .global_int_enable(gie), .busy(busy));

    // 40 MHz clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Busy cycle counter
    always @(posedge sys_clk) begin
        if (busy === 1'b1) busy_cnt++;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Classic single cycle, held until ack or err
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= lanes;
        adr <= {24'h0, a};
        wdat <= d;
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (ack === 1'b1 || err === 1'b1) break;
        end
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 16) begin
            error_cnt++;
            print_verdict;
        end
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // Preset state, run one operation, compare state and cycle count
    task op_case(input logic [4:0] op, input logic [31:0] cfg, input logic [7:0] mem,
        input logic [7:0] acc, input logic [7:0] flg, input logic [7:0] ea, input logic [7:0] em,
        input logic [7:0] ef, input logic [15:0] ep, input int ec);
        int n;
        xfer(1'b1, cpu_exec_pkg::ADDR_CFG, cfg);
        xfer(1'b1, cpu_exec_pkg::ADDR_MEM, {24'h0, mem});
        xfer(1'b1, cpu_exec_pkg::ADDR_ACC, {24'h0, acc});
        xfer(1'b1, cpu_exec_pkg::ADDR_FLAG, {24'h0, flg});
        xfer(1'b1, cpu_exec_pkg::ADDR_PC, 32'h0100);
        xfer(1'b1, cpu_exec_pkg::ADDR_STAT, 32'h1234);
        busy_cnt = 0;
        xfer(1'b1, cpu_exec_pkg::ADDR_CMD, {27'h0, op});
        for (n = 0; n < 8; n++) begin
            @(posedge sys_clk);
            if (busy !== 1'b1) break;
        end
        if (n == 8) begin
            error_cnt++;
            print_verdict;
        end
        chk(busy_cnt, ec);
        rd(cpu_exec_pkg::ADDR_ACC, {24'h0, ea});
        rd(cpu_exec_pkg::ADDR_MEM, {24'h0, em});
        rd(cpu_exec_pkg::ADDR_FLAG, {24'h0, ef});
        rd(cpu_exec_pkg::ADDR_PC, {16'h0, ep});
        $display("case op %h done", op);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(cpu_exec_pkg::ADDR_ACC, {24'h0, cpu_exec_pkg::ACC_RST});
        rd(cpu_exec_pkg::ADDR_FLAG, {24'h0, cpu_exec_pkg::FLAG_RST});
        rd(cpu_exec_pkg::ADDR_PC, {16'h0, cpu_exec_pkg::PC_RST});
        chk(gie, 1'b0);
        $display("reset test done");
        op_case(cpu_exec_pkg::OP_ROT_R_ACC, 24'h100000, 8'h81, 8'h00, 8'h00,
            8'h40, 8'h81, 8'h01, 16'h0101, 1);
        op_case(cpu_exec_pkg::OP_ROT_L_MEM, 24'h900000, 8'h81, 8'h00, 8'h01,
            8'h03, 8'h03, 8'h01, 16'h0101, 2);
        op_case(cpu_exec_pkg::OP_BIT_SET, 24'h100300, 8'h00, 8'h5a, 8'h07,
            8'h5a, 8'h08, 8'h07, 16'h0101, 1);
        op_case(cpu_exec_pkg::OP_BIT_CLR, 24'h900700, 8'hff, 8'h5a, 8'h00,
            8'h5a, 8'h7f, 8'h00, 16'h0101, 2);
        op_case(cpu_exec_pkg::OP_B0_BIT_SET, 24'h100800, 8'h00, 8'h5a, 8'h00,
            8'h5a, 8'h01, 8'h00, 16'h0101, 1);
        rd(cpu_exec_pkg::ADDR_STAT, 32'h00100100);
        op_case(cpu_exec_pkg::OP_B0_BIT_CLR, 24'h900d00, 8'hff, 8'h5a, 8'h00,
            8'h5a, 8'hdf, 8'h00, 16'h0101, 2);
        op_case(cpu_exec_pkg::OP_CMP_IMM, 24'h100005, 8'h00, 8'h05, 8'h00,
            8'h05, 8'h00, 8'h05, 16'h0102, 2);
        op_case(cpu_exec_pkg::OP_CMP_MEM, 24'h100000, 8'h05, 8'h03, 8'h07,
            8'h03, 8'h05, 8'h02, 16'h0101, 1);
        op_case(cpu_exec_pkg::OP_INC_ACC, 24'h900000, 8'hff, 8'h11, 8'h00,
            8'h00, 8'hff, 8'h00, 16'h0102, 2);
        op_case(cpu_exec_pkg::OP_INC_MEM, 24'h900000, 8'hff, 8'h11, 8'h07,
            8'h11, 8'h00, 8'h07, 16'h0102, 3);
        op_case(cpu_exec_pkg::OP_DEC_ACC, 24'h100000, 8'h05, 8'h11, 8'h07,
            8'h04, 8'h05, 8'h07, 16'h0101, 1);
        op_case(cpu_exec_pkg::OP_DEC_MEM, 24'h100000, 8'h01, 8'h11, 8'h00,
            8'h11, 8'h00, 8'h00, 16'h0102, 2);
        op_case(cpu_exec_pkg::OP_SKIP_CLR, 24'h100200, 8'h04, 8'h00, 8'h00,
            8'h00, 8'h04, 8'h00, 16'h0101, 1);
        op_case(cpu_exec_pkg::OP_SKIP_SET, 24'h900200, 8'h04, 8'h00, 8'h00,
            8'h00, 8'h04, 8'h00, 16'h0102, 2);
        op_case(cpu_exec_pkg::OP_B0_SKIP_CLR, 24'h100800, 8'h04, 8'h00, 8'h00,
            8'h00, 8'h04, 8'h00, 16'h0102, 2);
        rd(cpu_exec_pkg::ADDR_STAT, 32'h00100200);
        op_case(cpu_exec_pkg::OP_B0_SKIP_SET, 24'h100800, 8'h04, 8'h00, 8'h00,
            8'h00, 8'h04, 8'h00, 16'h0101, 1);
        op_case(cpu_exec_pkg::OP_NOP, 24'h0, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 16'h0101, 1);
        op_case(cpu_exec_pkg::OP_JMP, 24'h002000, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 16'h9234, 2);
        op_case(cpu_exec_pkg::OP_CALL, 24'h001000, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 16'h5234, 2);
        op_case(cpu_exec_pkg::OP_CALL, 24'h001000, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 16'h5234, 2);
        op_case(cpu_exec_pkg::OP_RET, 24'h0, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 16'h0101, 2);
        chk(gie, 1'b0);
        op_case(cpu_exec_pkg::OP_RETURN_FROM_INTERRUPT, 24'h0, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 16'h0101, 2);
        chk(gie, 1'b1);
        op_case(cpu_exec_pkg::OP_PUSH, 24'h0, 8'h00, 8'h3c, 8'hc5,
            8'h3c, 8'h00, 8'hc5, 16'h0101, 1);
        op_case(cpu_exec_pkg::OP_POP, 24'h0, 8'h00, 8'h00, 8'h82,
            8'h3c, 8'h00, 8'h85, 16'h0101, 1);
        // Lane 0 off leaves the accumulator alone; unmapped and misaligned get err
        lanes = 4'he;
        xfer(1'b1, cpu_exec_pkg::ADDR_ACC, 32'haa);
        lanes = 4'hf;
        rd(cpu_exec_pkg::ADDR_ACC, 32'h3c);
        xfer(1'b0, 8'h1c, 32'h0);
        chk(e, 1'b1);
        xfer(1'b0, 8'h06, 32'h0);
        chk(e, 1'b1);
        $display("bus test done");
        print_verdict;
    end
endmodule
